// >>> e1_ebit_loops_alarm_sim.sv
// E-bit handling, test loops and alarm simulation of a PCM 30 framer
//
// Summary of operation
// - Asynchronous state sends E-bits as zero, or one when async-high is set.
// - Multiframe synchronous state sends the programmed E-bits, or received CRC results under automatic insertion.
// - E-bits in frames 13 and 15: one is no error, zero is error.
// - Automatic insertion places received submultiframe status into outgoing E-bits.
// - Sixteen-bit counter of zero E-bits in frames 13 and 15.
// - Outside simulation, E-bit counter increments only in multiframe synchronous state.
// - Transparent mode takes outgoing E-bits from system transmit data.
// - One selected channel of 32 loops from system input to output.
// - Looped channel's line timeslot carries the programmed idle code.
// - Payload loop returns received data to line and still outputs it.
// - Payload loop with AIS-to-system sends all ones to the system.
// - Payload loop does not loop framing, CRC4 or spare bits.
// - Payload loop clocks transmitter from receive clock, ignores transmit input.
// - Local loop cuts line input, loops transmit data, still transmits it.
// - Local loop AIS-to-line sends AIS without changing looped data.
// - Remote loop returns line clock and data, optional jitter stage.
// - Alarm simulation keeps all channels carrying traffic.
// - Simulation hides real alarms from processor and remote end.
// - Simulation forces all six alarms, and the counters applicable for the mode.
// - Ending simulation removes simulated alarms; raised statuses stay pending.
// - Reading alarm status or an error counter clears it.
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module e1_ebit_loops_alarm_sim (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sys_tx_clock,
  input wire logic sys_rx_clock,
  input wire logic line_rx_clock,
  input wire logic line_rx_data,
  input wire logic sys_tx_data_in,
  input wire logic rx_bit_en,
  input wire logic rx_bit,
  input wire logic [3:0] rx_frame,
  input wire logic [4:0] rx_ts,
  input wire logic [2:0] rx_bitpos,
  input wire logic rx_mf_begin,
  input wire logic rx_mf_sync,
  input wire logic smf_done,
  input wire logic smf_crc_err,
  input wire logic rx_store_bit,
  input wire logic [3:0] tx_frame,
  input wire logic [4:0] tx_ts,
  input wire logic [2:0] tx_bitpos,
  input wire logic tx_core_bit,
  input wire logic [5:0] alarm_in,
  input wire logic lfa_in,
  input wire logic fas_err,
  input wire logic cv_err,
  input wire logic crc_err,
  input wire logic sa6a_err,
  input wire logic sa6b_err,
  output logic sys_rx_data_out,
  output logic line_tx_data,
  output logic line_tx_clock,
  output logic rcv_in_bit,
  output logic tx_bit_tick,
  output logic remote_alarm_out
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_ebit(input logic [3:0] fr, input logic [4:0] ts,
                                   input logic [2:0] bp);
    is_ebit = (ts == e1_pkg::TS_SERVICE) && (bp == e1_pkg::EBIT_BITPOS) &&
              (fr == e1_pkg::EBIT_FRAME_A || fr == e1_pkg::EBIT_FRAME_B);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [e1_pkg::NUM_PINS-1:0] pin_raw, pin_lvl, pin_rise;
  assign pin_raw = {sys_tx_data_in, line_rx_data, line_rx_clock, sys_rx_clock, sys_tx_clock};

  genvar gi;
  generate
    for (gi = 0; gi < e1_pkg::NUM_PINS; gi++) begin : g_sync
      pin_sync u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .pin(pin_raw[gi]),
        .level(pin_lvl[gi]),
        .rise(pin_rise[gi])
      );
    end
  endgenerate

  logic sclk_tx_rise, sclk_rx_rise, lclk_rise, lclk_lvl, lrx_data, stx_data;
  assign sclk_tx_rise = pin_rise[0];
  assign sclk_rx_rise = pin_rise[1];
  assign lclk_lvl = pin_lvl[2];
  assign lclk_rise = pin_rise[2];
  assign lrx_data = pin_lvl[3];
  assign stx_data = pin_lvl[4];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d;
  logic [4:0] spare_q, spare_d;
  logic [5:0] loop_q, loop_d;
  logic [7:0] idle_q, idle_d;
  logic [1:0] smf_ok_q, smf_ok_d;
  logic [1:0] si_q, si_d;
  logic [5:0] alm_state_q, alm_state_d;
  logic [5:0] alm_irq_q, alm_irq_d;
  logic [31:0] dat_q, dat_d;
  logic ack_q, ack_d;
  logic sys_rx_q, sys_rx_d;
  logic line_tx_q, line_tx_d;
  logic line_clk_q, line_clk_d;
  logic rcv_q, rcv_d;
  logic tick_q, tick_d;
  logic ra_q, ra_d;
  logic tx_pre_q, tx_pre_d;
  logic rl_dly_q, rl_dly_d;

  logic payload, ais_sys, local_lp, ais_line, remote_lp, jitter_atten_in_loop, sim, crc4;
  assign payload = ctrl_q[e1_pkg::CTRL_PAYLOAD];
  assign ais_sys = ctrl_q[e1_pkg::CTRL_AIS_SYS];
  assign local_lp = ctrl_q[e1_pkg::CTRL_LOCAL];
  assign ais_line = ctrl_q[e1_pkg::CTRL_AIS_LINE];
  assign remote_lp = ctrl_q[e1_pkg::CTRL_REMOTE];
  assign jitter_atten_in_loop = ctrl_q[e1_pkg::CTRL_JITTER_ATTEN_IN_LOOP];
  assign sim = ctrl_q[e1_pkg::CTRL_SIM];
  assign crc4 = ctrl_q[e1_pkg::CTRL_CRC4];

  logic scl_en;
  logic [4:0] scl_sel;
  assign scl_en = loop_q[e1_pkg::LOOP_EN];
  assign scl_sel = loop_q[4:0];

  // ----------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------
  logic [e1_pkg::NUM_CNT-1:0] cnt_inc, cnt_clr;
  logic [15:0] cnt_val [e1_pkg::NUM_CNT];
  logic rx_ezero;

  generate
    for (gi = 0; gi < e1_pkg::NUM_CNT; gi++) begin : g_cnt
      cor_counter u_cnt (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .inc(cnt_inc[gi]),
        .clr(cnt_clr[gi]),
        .count(cnt_val[gi])
      );
    end
  endgenerate

  assign rx_ezero = rx_bit_en && is_ebit(rx_frame, rx_ts, rx_bitpos) && !rx_bit;

  always_comb begin
    cnt_inc = '0;
    if (sim) begin
      // Simulated errors once per receive multiframe, only where applicable
      cnt_inc[e1_pkg::CNT_FAS] = rx_mf_begin;
      cnt_inc[e1_pkg::CNT_CV] = rx_mf_begin;
      cnt_inc[e1_pkg::CNT_CRC] = rx_mf_begin && crc4;
      cnt_inc[e1_pkg::CNT_EBIT] = rx_mf_begin && crc4;
      cnt_inc[e1_pkg::CNT_SA6A] = rx_mf_begin && crc4;
      cnt_inc[e1_pkg::CNT_SA6B] = rx_mf_begin && crc4;
    end else begin
      cnt_inc[e1_pkg::CNT_FAS] = fas_err;
      cnt_inc[e1_pkg::CNT_CV] = cv_err;
      cnt_inc[e1_pkg::CNT_CRC] = crc_err;
      cnt_inc[e1_pkg::CNT_EBIT] = rx_ezero && rx_mf_sync;
      cnt_inc[e1_pkg::CNT_SA6A] = sa6a_err;
      cnt_inc[e1_pkg::CNT_SA6B] = sa6b_err;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic req, wr, rd;
  logic [5:0] word;
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;
  assign word = wb_adr_i[7:2];

  always_comb begin
    for (int i = 0; i < e1_pkg::NUM_CNT; i++) begin
      cnt_clr[i] = rd && (word == 6'(e1_pkg::OFS_CNT_BASE[7:2] + 6'(i)));
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic e_val, tx_tick, rx_out_bit;
  logic [5:0] alm_live;

  always_comb begin
    ctrl_d = ctrl_q;
    spare_d = spare_q;
    loop_d = loop_q;
    idle_d = idle_q;
    ack_d = req;
    dat_d = 32'h0000_0000;
    if (wr) begin
      case (wb_adr_i)
        e1_pkg::OFS_CTRL: ctrl_d = wb_dat_i[7:0];
        e1_pkg::OFS_SPARE: spare_d = wb_dat_i[4:0];
        e1_pkg::OFS_LOOP: loop_d = wb_dat_i[5:0];
        e1_pkg::OFS_IDLE: idle_d = wb_dat_i[7:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (wb_adr_i)
        e1_pkg::OFS_CTRL: dat_d = {24'h000000, ctrl_q};
        e1_pkg::OFS_SPARE: dat_d = {27'h0000000, spare_q};
        e1_pkg::OFS_LOOP: dat_d = {26'h0000000, loop_q};
        e1_pkg::OFS_IDLE: dat_d = {24'h000000, idle_q};
        e1_pkg::OFS_RXSTAT: dat_d = {29'h00000000, rx_mf_sync, si_q};
        e1_pkg::OFS_ALM_IRQ: dat_d = {26'h0000000, alm_irq_q};
        e1_pkg::OFS_ALM_STATE: dat_d = {26'h0000000, alm_state_q};
        default: begin
          for (int i = 0; i < e1_pkg::NUM_CNT; i++) begin
            if (cnt_clr[i]) begin
              dat_d = {16'h0000, cnt_val[i]};
            end
          end
        end
      endcase
    end

    // Submultiframe results, one means no CRC error
    smf_ok_d = smf_ok_q;
    if (smf_done) begin
      if (rx_frame < 4'h8) begin
        smf_ok_d[0] = !smf_crc_err;
      end else begin
        smf_ok_d[1] = !smf_crc_err;
      end
    end
    si_d = rx_mf_begin ? smf_ok_q : si_q;

    // Alarms: simulation replaces live state, real ones stay hidden
    alm_live = sim ? {e1_pkg::NUM_ALARMS{1'b1}} : alarm_in;
    alm_state_d = alm_live;
    alm_irq_d = alm_irq_q;
    if (rd && wb_adr_i == e1_pkg::OFS_ALM_IRQ) begin
      alm_irq_d = '0;
    end
    alm_irq_d = alm_irq_d | (alm_live & ~alm_state_q);
    ra_d = lfa_in && !sim;

    // Outgoing E-bit value
    if (spare_q[e1_pkg::SP_TRANSP]) begin
      e_val = stx_data;
    end else if (sim) begin
      e_val = 1'b1;
    end else if (rx_mf_sync) begin
      if (spare_q[e1_pkg::SP_AUTO]) begin
        e_val = (tx_frame == e1_pkg::EBIT_FRAME_A) ? si_q[0] : si_q[1];
      end else begin
        e_val = (tx_frame == e1_pkg::EBIT_FRAME_A) ? spare_q[e1_pkg::SP_EBIT_A] :
                spare_q[e1_pkg::SP_EBIT_B];
      end
    end else begin
      e_val = spare_q[e1_pkg::SP_ASYNC_HIGH];
    end

    // Transmit side advances on the selected system clock
    tx_tick = payload ? sclk_rx_rise : sclk_tx_rise;
    tick_d = tx_tick;
    tx_pre_d = tx_pre_q;
    if (tx_tick) begin
      if (tx_ts == e1_pkg::TS_SERVICE) begin
        tx_pre_d = is_ebit(tx_frame, tx_ts, tx_bitpos) ? e_val : tx_core_bit;
      end else if (scl_en && tx_ts == scl_sel) begin
        tx_pre_d = idle_q[3'h7 - tx_bitpos];
      end else begin
        tx_pre_d = payload ? rx_store_bit : stx_data;
      end
    end

    // Line output: remote loop bypasses the transmitter
    rl_dly_d = lclk_rise ? lrx_data : rl_dly_q;
    line_tx_d = line_tx_q;
    line_clk_d = line_clk_q;
    if (remote_lp) begin
      line_clk_d = lclk_lvl;
      if (lclk_rise) begin
        line_tx_d = jitter_atten_in_loop ? rl_dly_q : lrx_data;
      end
    end else begin
      line_clk_d = payload ? pin_lvl[1] : pin_lvl[0];
      if (tick_q) begin
        line_tx_d = ais_line ? 1'b1 : tx_pre_q;
      end
    end

    // Receiver input: local loop cuts off the line
    rcv_d = local_lp ? tx_pre_q : lrx_data;

    // System receive output
    if (payload && ais_sys) begin
      rx_out_bit = 1'b1;
    end else if (scl_en && rx_ts == scl_sel) begin
      rx_out_bit = stx_data;
    end else begin
      rx_out_bit = rx_store_bit;
    end
    sys_rx_d = rx_bit_en ? rx_out_bit : sys_rx_q;
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_q <= e1_pkg::CTRL_RESET;
      spare_q <= e1_pkg::SPARE_RESET;
      loop_q <= 6'h00;
      idle_q <= e1_pkg::IDLE_RESET;
      smf_ok_q <= 2'h3;
      si_q <= 2'h3;
      alm_state_q <= 6'h00;
      alm_irq_q <= 6'h00;
      dat_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      sys_rx_q <= 1'b1;
      line_tx_q <= 1'b1;
      line_clk_q <= 1'b0;
      rcv_q <= 1'b0;
      tick_q <= 1'b0;
      ra_q <= 1'b0;
      tx_pre_q <= 1'b1;
      rl_dly_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      spare_q <= spare_d;
      loop_q <= loop_d;
      idle_q <= idle_d;
      smf_ok_q <= smf_ok_d;
      si_q <= si_d;
      alm_state_q <= alm_state_d;
      alm_irq_q <= alm_irq_d;
      dat_q <= dat_d;
      ack_q <= ack_d;
      sys_rx_q <= sys_rx_d;
      line_tx_q <= line_tx_d;
      line_clk_q <= line_clk_d;
      rcv_q <= rcv_d;
      tick_q <= tick_d;
      ra_q <= ra_d;
      tx_pre_q <= tx_pre_d;
      rl_dly_q <= rl_dly_d;
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign sys_rx_data_out = sys_rx_q;
  assign line_tx_data = line_tx_q;
  assign line_tx_clock = line_clk_q;
  assign rcv_in_bit = rcv_q;
  assign tx_bit_tick = tick_q;
  assign remote_alarm_out = ra_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_alm_read;
    rd && wb_adr_i == e1_pkg::OFS_ALM_IRQ && !sim && alarm_in == 6'h00;
  endsequence

  sequence s_e_async_tick;
    tx_tick && is_ebit(tx_frame, tx_ts, tx_bitpos) && !rx_mf_sync && !sim &&
    !spare_q[e1_pkg::SP_TRANSP] && !ais_line && !remote_lp && !wr;
  endsequence

  property p_ebit_count;
    @(posedge clk_sys) disable iff (!resetn)
    rx_ezero && rx_mf_sync && !sim && !cnt_clr[e1_pkg::CNT_EBIT] &&
    cnt_val[e1_pkg::CNT_EBIT] != 16'hffff |=>
    cnt_val[e1_pkg::CNT_EBIT] == $past(cnt_val[e1_pkg::CNT_EBIT]) + 16'h0001;
  endproperty
  a_ebit_count: assert property (p_ebit_count) else $error("E-bit zero not counted");

  property p_ebit_nosync;
    @(posedge clk_sys) disable iff (!resetn)
    !rx_mf_sync && !sim && !cnt_clr[e1_pkg::CNT_EBIT] |=> $stable(cnt_val[e1_pkg::CNT_EBIT]);
  endproperty
  a_ebit_nosync: assert property (p_ebit_nosync) else $error("E-bit counted out of sync");

  property p_e_async;
    @(posedge clk_sys) disable iff (!resetn)
    s_e_async_tick ##1 tick_q |=> line_tx_data == $past(spare_q[e1_pkg::SP_ASYNC_HIGH], 2);
  endproperty
  a_e_async: assert property (p_e_async) else $error("Async E-bit value wrong");

  property p_scl_loop;
    @(posedge clk_sys) disable iff (!resetn)
    rx_bit_en && scl_en && rx_ts == scl_sel && !payload |=> sys_rx_data_out == $past(stx_data);
  endproperty
  a_scl_loop: assert property (p_scl_loop) else $error("Looped channel data wrong");

  property p_ais_sys;
    @(posedge clk_sys) disable iff (!resetn)
    rx_bit_en && payload && ais_sys |=> sys_rx_data_out;
  endproperty
  a_ais_sys: assert property (p_ais_sys) else $error("AIS to system missing");

  property p_local;
    @(posedge clk_sys) disable iff (!resetn)
    local_lp |=> rcv_in_bit == $past(tx_pre_q);
  endproperty
  a_local: assert property (p_local) else $error("Local loop input wrong");

  property p_sim_ra;
    @(posedge clk_sys) disable iff (!resetn)
    sim |=> !remote_alarm_out;
  endproperty
  a_sim_ra: assert property (p_sim_ra) else $error("Real alarm sent during simulation");

  property p_alm_clear;
    @(posedge clk_sys) disable iff (!resetn)
    s_alm_read |=> alm_irq_q == 6'h00;
  endproperty
  a_alm_clear: assert property (p_alm_clear) else $error("Status not cleared on read");

  property p_ack_pulse;
    @(posedge clk_sys) disable iff (!resetn)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Ack longer than one cycle");
endmodule

// >>> e1_pkg.sv
// Shared constants for the E-bit, test loop and alarm simulation block
package e1_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SPARE = 8'h04;
  localparam logic [7:0] OFS_LOOP = 8'h08;
  localparam logic [7:0] OFS_IDLE = 8'h0c;
  localparam logic [7:0] OFS_RXSTAT = 8'h10;
  localparam logic [7:0] OFS_ALM_IRQ = 8'h14;
  localparam logic [7:0] OFS_ALM_STATE = 8'h18;
  localparam logic [7:0] OFS_CNT_BASE = 8'h1c;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_PAYLOAD = 0;
  localparam int CTRL_AIS_SYS = 1;
  localparam int CTRL_LOCAL = 2;
  localparam int CTRL_AIS_LINE = 3;
  localparam int CTRL_REMOTE = 4;
  localparam int CTRL_JITTER_ATTEN_IN_LOOP = 5;
  localparam int CTRL_SIM = 6;
  localparam int CTRL_CRC4 = 7;
  localparam int SP_EBIT_A = 0;
  localparam int SP_EBIT_B = 1;
  localparam int SP_ASYNC_HIGH = 2;
  localparam int SP_AUTO = 3;
  localparam int SP_TRANSP = 4;
  localparam int LOOP_EN = 5;
  // ----------------------------------------------------------------
  // Reset values, frame positions, counters
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [4:0] SPARE_RESET = 5'h03;
  localparam logic [7:0] IDLE_RESET = 8'hd5;
  localparam logic [3:0] EBIT_FRAME_A = 4'hd;
  localparam logic [3:0] EBIT_FRAME_B = 4'hf;
  localparam logic [4:0] TS_SERVICE = 5'h00;
  localparam logic [2:0] EBIT_BITPOS = 3'h0;
  localparam int NUM_ALARMS = 6;
  localparam int NUM_CNT = 6;
  localparam int CNT_FAS = 0;
  localparam int CNT_CV = 1;
  localparam int CNT_CRC = 2;
  localparam int CNT_EBIT = 3;
  localparam int CNT_SA6A = 4;
  localparam int CNT_SA6B = 5;
  localparam int NUM_PINS = 5;
endpackage

// >>> pin_sync.sv
// Two-stage pin synchroniser with rising-edge pulse
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic prev_q, prev_d;

  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
endmodule

// >>> cor_counter.sv
// 16-bit event counter cleared by a read; a count in the clear cycle restarts it at one
`timescale 1ns/1ps
module cor_counter (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic inc,
  input wire logic clr,
  output logic [15:0] count
);
  logic [15:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (clr) begin
      cnt_d = {15'h0000, inc};
    end else if (inc && cnt_q != 16'hffff) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;
endmodule

// >>> line_partner.sv
// Far-end line model: free-running pin clocks and toggling line data
`timescale 1ns/1ps
module line_partner (
  output logic tx_clk,
  output logic rx_clk,
  output logic ln_clk,
  output logic ln_data
);
  initial begin
    tx_clk = 1'b0;
    rx_clk = 1'b0;
    ln_clk = 1'b0;
    ln_data = 1'b1;
  end
  always #100 tx_clk = ~tx_clk;
  always #103 rx_clk = ~rx_clk;
  always #97 ln_clk = ~ln_clk;
  always @(negedge ln_clk) ln_data <= ~ln_data;
endmodule

// >>> testbench.sv
// Self-checking bench for the E-bit, loop and alarm simulation block
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rd_v;
  logic tx_clk, rx_clk, ln_clk, ln_data, rx_out, ln_tx, ln_tx_clk, rcv_bit, tick, ra_out;
  logic rx_en = 1'b0, rx_bit = 1'b0, mf_beg = 1'b0, mf_sync = 1'b0, lfa = 1'b0;
  logic [3:0] rx_frame = 4'h0, tx_frame = 4'h0;
  logic [4:0] errs = 5'h00;
  logic [5:0] alarms = 6'h00;
  logic stx_in = 1'b1, store_bit = 1'b1, smf = 1'b0, smf_err = 1'b0, lp_ok;
  int num_errors = 0;
  int num_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  line_partner far_end (.tx_clk(tx_clk), .rx_clk(rx_clk), .ln_clk(ln_clk), .ln_data(ln_data));
  e1_ebit_loops_alarm_sim dut (
    .clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .sys_tx_clock(tx_clk), .sys_rx_clock(rx_clk),
    .line_rx_clock(ln_clk), .line_rx_data(ln_data), .sys_tx_data_in(stx_in),
    .rx_bit_en(rx_en), .rx_bit(rx_bit), .rx_frame(rx_frame), .rx_ts(5'h00),
    .rx_bitpos(3'h0), .rx_mf_begin(mf_beg), .rx_mf_sync(mf_sync), .smf_done(smf),
    .smf_crc_err(smf_err), .rx_store_bit(store_bit), .tx_frame(tx_frame), .tx_ts(5'h00),
    .tx_bitpos(3'h0), .tx_core_bit(1'b1), .alarm_in(alarms), .lfa_in(lfa),
    .fas_err(errs[0]), .cv_err(errs[1]), .crc_err(errs[2]), .sa6a_err(errs[3]),
    .sa6b_err(errs[4]), .sys_rx_data_out(rx_out), .line_tx_data(ln_tx),
    .line_tx_clock(ln_tx_clk), .rcv_in_bit(rcv_bit), .tx_bit_tick(tick),
    .remote_alarm_out(ra_out)
  );
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= dat;
    wb_sel <= 4'hf;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd_v = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    chk(rd_v, exp);
  endtask
  task automatic rx_ebit(input logic [3:0] fr, input logic b);
    @(posedge clk_sys);
    rx_en <= 1'b1;
    rx_frame <= fr;
    rx_bit <= b;
    @(posedge clk_sys);
    rx_en <= 1'b0;
  endtask
  task automatic tx_ebit(input logic sync, input logic [7:0] spare, input logic exp);
    int n;
    mf_sync <= sync;
    wr(e1_pkg::OFS_SPARE, {24'h0, spare});
    n = 0;
    repeat (2) begin
      do begin
        @(negedge clk_sys);
        n++;
      end while (tick !== 1'b1 && n < 100);
      @(negedge clk_sys);
    end
    if (n >= 100) num_errors++;
    chk({31'h0, ln_tx}, {31'h0, exp});
    @(posedge clk_sys);
  endtask
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(e1_pkg::OFS_CTRL, {24'h0, e1_pkg::CTRL_RESET});
    rd(e1_pkg::OFS_SPARE, {27'h0, e1_pkg::SPARE_RESET});
    rd(e1_pkg::OFS_IDLE, {24'h0, e1_pkg::IDLE_RESET});
    rd(8'hfc, 32'h0);
    wr(e1_pkg::OFS_LOOP, 32'h0000003f);
    rd(e1_pkg::OFS_LOOP, 32'h0000003f);
    wr(e1_pkg::OFS_LOOP, 32'h0);
    stx_in <= 1'b0;
    tx_frame <= e1_pkg::EBIT_FRAME_A;
    wr(e1_pkg::OFS_LOOP, 32'h20);
    rx_ebit(4'h0, 1'b1);
    @(negedge clk_sys);
    chk({31'h0, rx_out}, 32'h0);
    wr(e1_pkg::OFS_LOOP, 32'h0);
    tx_ebit(1'b1, 8'h10, 1'b0);
    rx_ebit(4'h0, 1'b1);
    @(negedge clk_sys);
    chk({31'h0, rx_out}, 32'h1);
    @(posedge clk_sys);
    stx_in <= 1'b1;
    tx_ebit(1'b0, 8'h03, 1'b0);
    tx_ebit(1'b0, 8'h07, 1'b1);
    tx_ebit(1'b1, 8'h04, 1'b0);
    tx_ebit(1'b1, 8'h05, 1'b1);
    wr(e1_pkg::OFS_CTRL, 32'h04);
    lp_ok = 1'b1;
    repeat (16) begin
      @(negedge clk_sys);
      lp_ok = lp_ok & rcv_bit;
    end
    chk({31'h0, lp_ok}, 32'h1);
    @(posedge clk_sys);
    store_bit <= 1'b0;
    wr(e1_pkg::OFS_CTRL, 32'h01);
    rx_ebit(4'h0, 1'b1);
    @(negedge clk_sys);
    chk({31'h0, rx_out}, 32'h0);
    wr(e1_pkg::OFS_CTRL, 32'h03);
    rx_ebit(4'h0, 1'b1);
    @(negedge clk_sys);
    chk({31'h0, rx_out}, 32'h1);
    wr(e1_pkg::OFS_CTRL, 32'h0);
    store_bit <= 1'b1;
    rx_ebit(e1_pkg::EBIT_FRAME_A, 1'b0);
    rx_ebit(e1_pkg::EBIT_FRAME_B, 1'b0);
    rx_ebit(e1_pkg::EBIT_FRAME_A, 1'b1);
    mf_sync <= 1'b0;
    rx_ebit(e1_pkg::EBIT_FRAME_B, 1'b0);
    rd(8'h28, 32'h2);
    rd(8'h28, 32'h0);
    mf_sync <= 1'b1;
    @(posedge clk_sys);
    errs <= 5'h1f;
    @(posedge clk_sys);
    errs <= 5'h00;
    rd(8'h1c, 32'h1);
    rd(8'h20, 32'h1);
    rd(8'h24, 32'h1);
    rd(8'h2c, 32'h1);
    rd(8'h30, 32'h1);
    @(posedge clk_sys);
    smf <= 1'b1;
    smf_err <= 1'b1;
    rx_frame <= 4'h2;
    @(posedge clk_sys);
    smf <= 1'b0;
    smf_err <= 1'b0;
    mf_beg <= 1'b1;
    @(posedge clk_sys);
    mf_beg <= 1'b0;
    rd(e1_pkg::OFS_RXSTAT, 32'h6);
    tx_ebit(1'b1, 8'h08, 1'b0);
    alarms <= 6'h05;
    repeat (2) @(posedge clk_sys);
    rd(e1_pkg::OFS_ALM_STATE, 32'h5);
    rd(e1_pkg::OFS_ALM_IRQ, 32'h5);
    alarms <= 6'h00;
    wr(e1_pkg::OFS_CTRL, 32'h40);
    lfa <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(e1_pkg::OFS_ALM_STATE, 32'h3f);
    @(negedge clk_sys);
    chk({31'h0, ra_out}, 32'h0);
    wr(e1_pkg::OFS_CTRL, 32'h0);
    rd(e1_pkg::OFS_ALM_STATE, 32'h0);
    rd(e1_pkg::OFS_ALM_IRQ, 32'h3f);
    rd(e1_pkg::OFS_ALM_IRQ, 32'h0);
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({31'h0, ra_out}, 32'h1);
    end_sim();
  end
endmodule
